// file: rtl/mpiu_top.sv
// interrupt unit: apb option register, source latches, dispatch, flag sets
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module mpiu_top #(
  parameter int PINS = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_pin_n,
  input wire logic [PINS-1:0] port_pin_n,
  input wire logic [PINS-1:0] port_pin_irq_en,
  input wire logic spi_eot_evt,
  input wire logic spi_irq_enable,
  input wire logic timer1_overflow_evt,
  input wire logic timer1_irq_enable,
  input wire logic reload_overflow_evt,
  input wire logic reload_overflow_irq_enable,
  input wire logic reload_compare_evt,
  input wire logic reload_compare_irq_enable,
  input wire logic serial_rx_evt,
  input wire logic serial_rx_irq_enable,
  input wire logic serial_tx_evt,
  input wire logic serial_tx_irq_enable,
  input wire logic converter_eoc_evt,
  input wire logic converter_irq_enable,
  input wire logic instr_done,
  input wire logic return_from_interrupt,
  input wire logic sleep_req,
  output logic irq_take,
  output logic [11:0] irq_vector,
  output logic pc_push,
  output logic pc_pop,
  output logic [1:0] flag_set_sel,
  output logic sleeping,
  output logic wake,
  output logic sleep_refused
);

  // pin synchronisers; first stage feeds only the second
  logic nmi_m_ff, nmi_s_ff, nmi_prev_ff;
  logic [PINS-1:0] pin_m_ff, pin_s_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_m_ff <= 1'b1;
      nmi_s_ff <= 1'b1;
      nmi_prev_ff <= 1'b1;
      pin_m_ff <= '1;
      pin_s_ff <= '1;
    end
    else
    begin
      nmi_m_ff <= nmi_pin_n;
      nmi_s_ff <= nmi_m_ff;
      nmi_prev_ff <= nmi_s_ff;
      pin_m_ff <= port_pin_n;
      pin_s_ff <= pin_m_ff;
    end
  end

  // apb slave and register state
  localparam int NUM_EV = mpiu_pkg::NUM_EVENTS;
  logic [7:0] option_ff, nxt_option;
  logic [NUM_EV-1:0] events_ff, nxt_events;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  // interrupt state
  logic lat1_ff, nxt_lat1;
  logic lat2_ff, nxt_lat2;
  logic line1_prev_ff, nxt_line1_prev;
  logic line2_prev_ff, nxt_line2_prev;
  logic nmi_lat_ff, nxt_nmi_lat;
  logic in_int_ff, nxt_in_int;
  logic in_nmi_ff, nxt_in_nmi;
  logic nmi_over_int_ff, nxt_nmi_over_int;
  logic take_ff, nxt_take;
  logic [11:0] vector_ff, nxt_vector;
  logic push_ff, nxt_push;
  logic pop_ff, nxt_pop;
  mpiu_pkg::mpiu_flags_e flags_ff, nxt_flags;
  logic sleeping_ff, nxt_sleeping;
  logic wake_ff, nxt_wake;
  logic refused_ff, nxt_refused;

  logic gen, source1_level_select, source2_edge_polarity;
  logic line1_n, line2_n;
  logic req1, req2, req3, req4;
  logic [NUM_EV-1:0] ev_in, ev_en;
  logic any_mreq, pend_enabled, bus_access;
  logic [7:0] status_word;
  logic edge1, edge2, nmi_edge;

  assign gen = option_ff[mpiu_pkg::BIT_GLOBAL_EN];
  assign source1_level_select = option_ff[mpiu_pkg::BIT_SRC1_LEVEL];
  assign source2_edge_polarity = option_ff[mpiu_pkg::BIT_SRC2_POL];
  assign edge1 = !source1_level_select && line1_prev_ff && !line1_n;
  assign edge2 = source2_edge_polarity ? (!line2_prev_ff && line2_n)
    : (line2_prev_ff && !line2_n);
  assign nmi_edge = nmi_prev_ff && !nmi_s_ff;

  assign ev_in = {converter_eoc_evt, serial_tx_evt, serial_rx_evt,
    reload_compare_evt, reload_overflow_evt, timer1_overflow_evt,
    spi_eot_evt};
  assign ev_en = {converter_irq_enable, serial_tx_irq_enable,
    serial_rx_irq_enable, reload_compare_irq_enable,
    reload_overflow_irq_enable, timer1_irq_enable, spi_irq_enable};

  // source lines are active low, as at the core boundary
  assign line1_n = ~(events_ff[mpiu_pkg::EV_SPI] & ev_en[mpiu_pkg::EV_SPI]);
  assign line2_n = ~|(~pin_s_ff & port_pin_irq_en);
  assign req1 = source1_level_select ? ~line1_n : lat1_ff;
  assign req2 = lat2_ff;
  assign req3 = |(events_ff[mpiu_pkg::EV_RL_CMP:mpiu_pkg::EV_T1_OVF]
    & ev_en[mpiu_pkg::EV_RL_CMP:mpiu_pkg::EV_T1_OVF]);
  assign req4 = |(events_ff[mpiu_pkg::EV_EOC:mpiu_pkg::EV_RX]
    & ev_en[mpiu_pkg::EV_EOC:mpiu_pkg::EV_RX]);
  assign any_mreq = req1 | req2 | req3 | req4;
  assign pend_enabled = nmi_lat_ff | (gen & any_mreq);
  assign bus_access = psel & penable & pready_ff;
  assign status_word = {1'b0, nmi_over_int_ff, in_nmi_ff, in_int_ff,
    req4, req3, req2, req1};

  always_comb
  begin
    nxt_option = option_ff;
    nxt_events = events_ff | ev_in;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff)
    begin
      nxt_pready = 1'b1;
      nxt_prdata = 32'h0000_0000;
      unique case (paddr)
        mpiu_pkg::ADDR_OPTION: nxt_prdata = 32'h0000_0000;
        mpiu_pkg::ADDR_STATUS: nxt_prdata = {24'h00_0000, status_word};
        mpiu_pkg::ADDR_EVENTS:
          nxt_prdata = {{(32-NUM_EV){1'b0}}, events_ff};
        default: nxt_pslverr = 1'b1;
      endcase
      if (pwrite && paddr == mpiu_pkg::ADDR_STATUS)
        nxt_pslverr = 1'b1;
    end
    if (bus_access && pwrite)
    begin
      // whole byte only; unused bits stored as zero
      if (paddr == mpiu_pkg::ADDR_OPTION)
        nxt_option = pwdata[7:0] & 8'h70;
      // clear by writing one; a new event in the same cycle wins
      if (paddr == mpiu_pkg::ADDR_EVENTS)
        nxt_events = (events_ff & ~pwdata[NUM_EV-1:0]) | ev_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_ff <= mpiu_pkg::OPTION_RESET;
      events_ff <= '0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      option_ff <= nxt_option;
      events_ff <= nxt_events;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // dispatch, latches, mode tracking and sleep control
  always_comb
  begin
    nxt_line1_prev = line1_n;
    nxt_line2_prev = line2_n;
    nxt_lat1 = lat1_ff;
    nxt_lat2 = lat2_ff;
    nxt_nmi_lat = nmi_lat_ff;
    nxt_in_int = in_int_ff;
    nxt_in_nmi = in_nmi_ff;
    nxt_nmi_over_int = nmi_over_int_ff;
    nxt_take = 1'b0;
    nxt_vector = vector_ff;
    nxt_push = 1'b0;
    nxt_pop = 1'b0;
    nxt_flags = flags_ff;
    nxt_sleeping = sleeping_ff;
    nxt_wake = 1'b0;
    nxt_refused = 1'b0;
    // a second edge before service finds the latch already set
    if (!source1_level_select && line1_prev_ff && !line1_n)
      nxt_lat1 = 1'b1;
    if (source1_level_select)
      nxt_lat1 = 1'b0;
    if (source2_edge_polarity ? (!line2_prev_ff && line2_n) : (line2_prev_ff && !line2_n))
      nxt_lat2 = 1'b1;
    if (nmi_prev_ff && !nmi_s_ff)
      nxt_nmi_lat = 1'b1;
    if (sleeping_ff)
    begin
      // nmi too is held asleep while global enable is clear
      if (gen && (nmi_lat_ff || any_mreq))
      begin
        nxt_sleeping = 1'b0;
        nxt_wake = 1'b1;
      end
    end
    else if (instr_done)
    begin
      if (nmi_lat_ff && !in_nmi_ff)
      begin
        nxt_take = 1'b1;
        nxt_vector = mpiu_pkg::VEC_SRC0;
        // a fresh edge in the take cycle wins over the clear
        nxt_nmi_lat = nmi_edge;
        nxt_in_nmi = 1'b1;
        nxt_nmi_over_int = in_int_ff;
        nxt_flags = mpiu_pkg::MPIU_FLAGS_NMI;
        nxt_push = 1'b1;
      end
      else if (gen && any_mreq && !in_int_ff && !in_nmi_ff)
      begin
        nxt_take = 1'b1;
        nxt_in_int = 1'b1;
        nxt_flags = mpiu_pkg::MPIU_FLAGS_INT;
        nxt_push = 1'b1;
        if (req1)
        begin
          nxt_vector = mpiu_pkg::VEC_SRC1;
          nxt_lat1 = edge1;
        end
        else if (req2)
        begin
          nxt_vector = mpiu_pkg::VEC_SRC2;
          nxt_lat2 = edge2;
        end
        else if (req3)
          nxt_vector = mpiu_pkg::VEC_SRC3;
        else
          nxt_vector = mpiu_pkg::VEC_SRC4;
      end
    end
    else if (return_from_interrupt && (in_int_ff || in_nmi_ff))
    begin
      nxt_pop = 1'b1;
      if (in_nmi_ff)
      begin
        nxt_in_nmi = 1'b0;
        nxt_nmi_over_int = 1'b0;
        nxt_flags = nmi_over_int_ff ? mpiu_pkg::MPIU_FLAGS_INT
          : mpiu_pkg::MPIU_FLAGS_NORMAL;
      end
      else
      begin
        nxt_in_int = 1'b0;
        nxt_flags = mpiu_pkg::MPIU_FLAGS_NORMAL;
      end
    end
    else if (sleep_req)
    begin
      if (pend_enabled)
        nxt_refused = 1'b1;
      else
        nxt_sleeping = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line1_prev_ff <= 1'b1;
      line2_prev_ff <= 1'b1;
      lat1_ff <= 1'b0;
      lat2_ff <= 1'b0;
      nmi_lat_ff <= 1'b0;
      in_int_ff <= 1'b0;
      in_nmi_ff <= 1'b0;
      nmi_over_int_ff <= 1'b0;
      take_ff <= 1'b0;
      vector_ff <= 12'h000;
      push_ff <= 1'b0;
      pop_ff <= 1'b0;
      flags_ff <= mpiu_pkg::MPIU_FLAGS_NORMAL;
      sleeping_ff <= 1'b0;
      wake_ff <= 1'b0;
      refused_ff <= 1'b0;
    end
    else
    begin
      line1_prev_ff <= nxt_line1_prev;
      line2_prev_ff <= nxt_line2_prev;
      lat1_ff <= nxt_lat1;
      lat2_ff <= nxt_lat2;
      nmi_lat_ff <= nxt_nmi_lat;
      in_int_ff <= nxt_in_int;
      in_nmi_ff <= nxt_in_nmi;
      nmi_over_int_ff <= nxt_nmi_over_int;
      take_ff <= nxt_take;
      vector_ff <= nxt_vector;
      push_ff <= nxt_push;
      pop_ff <= nxt_pop;
      flags_ff <= nxt_flags;
      sleeping_ff <= nxt_sleeping;
      wake_ff <= nxt_wake;
      refused_ff <= nxt_refused;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_take = take_ff;
  assign irq_vector = vector_ff;
  assign pc_push = push_ff;
  assign pc_pop = pop_ff;
  assign flag_set_sel = flags_ff;
  assign sleeping = sleeping_ff;
  assign wake = wake_ff;
  assign sleep_refused = refused_ff;

  property p_nmi_first;
    @(posedge pclk) disable iff (!presetn)
    instr_done && !sleeping_ff && nmi_lat_ff && !in_nmi_ff
    |=> take_ff && vector_ff == mpiu_pkg::VEC_SRC0
      && nmi_lat_ff == $past(nmi_edge)
      && flags_ff == mpiu_pkg::MPIU_FLAGS_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first)
    else $error("nmi not dispatched first");

  property p_no_mask_nest;
    @(posedge pclk) disable iff (!presetn)
    (in_int_ff || in_nmi_ff) && instr_done
    |=> !(take_ff && vector_ff != mpiu_pkg::VEC_SRC0);
  endproperty
  a_no_mask_nest: assert property (p_no_mask_nest)
    else $error("maskable request nested");

  property p_src1_wins;
    @(posedge pclk) disable iff (!presetn)
    instr_done && !sleeping_ff && gen && req1 && !nmi_lat_ff
      && !in_int_ff && !in_nmi_ff
    |=> take_ff && vector_ff == mpiu_pkg::VEC_SRC1
      && flags_ff == mpiu_pkg::MPIU_FLAGS_INT;
  endproperty
  a_src1_wins: assert property (p_src1_wins)
    else $error("source 1 not served first");

  property p_src4_last;
    @(posedge pclk) disable iff (!presetn)
    take_ff && vector_ff == mpiu_pkg::VEC_SRC4
    |-> $past(!req1 && !req2 && !req3 && req4 && gen);
  endproperty
  a_src4_last: assert property (p_src4_last)
    else $error("source 4 served over higher one");

  property p_gen_blocks;
    @(posedge pclk) disable iff (!presetn)
    !gen ##1 take_ff |-> vector_ff == mpiu_pkg::VEC_SRC0;
  endproperty
  a_gen_blocks: assert property (p_gen_blocks)
    else $error("maskable taken with enable clear");

  property p_no_wake_gen_low;
    @(posedge pclk) disable iff (!presetn)
    sleeping_ff && !gen |=> !wake_ff && sleeping_ff;
  endproperty
  a_no_wake_gen_low: assert property (p_no_wake_gen_low)
    else $error("wake while enable clear");

  property p_entry_push;
    @(posedge pclk) disable iff (!presetn)
    take_ff |-> push_ff && (in_int_ff || in_nmi_ff) && !pop_ff;
  endproperty
  a_entry_push: assert property (p_entry_push)
    else $error("entry without pc push");

  property p_return_from_interrupt_nested;
    @(posedge pclk) disable iff (!presetn)
    return_from_interrupt && !instr_done && !sleeping_ff && in_nmi_ff
      && nmi_over_int_ff
    |=> pc_pop && flags_ff == mpiu_pkg::MPIU_FLAGS_INT && in_int_ff;
  endproperty
  a_return_from_interrupt_nested: assert property (p_return_from_interrupt_nested)
    else $error("return lost interrupt flag set");

  property p_refuse_sleep;
    @(posedge pclk) disable iff (!presetn)
    sleep_req && !instr_done && !return_from_interrupt && !sleeping_ff
      && pend_enabled
    |=> refused_ff && !sleeping_ff;
  endproperty
  a_refuse_sleep: assert property (p_refuse_sleep)
    else $error("sleep entered with request pending");

  property p_option_write;
    @(posedge pclk) disable iff (!presetn)
    bus_access && pwrite && paddr == mpiu_pkg::ADDR_OPTION
    |=> option_ff == ($past(pwdata[7:0]) & 8'h70);
  endproperty
  a_option_write: assert property (p_option_write)
    else $error("option write not stored");

  property p_edge_latch_hold;
    @(posedge pclk) disable iff (!presetn)
    lat2_ff && !(take_ff && vector_ff == mpiu_pkg::VEC_SRC2)
    |=> lat2_ff || (take_ff && vector_ff == mpiu_pkg::VEC_SRC2);
  endproperty
  a_edge_latch_hold: assert property (p_edge_latch_hold)
    else $error("edge latch lost before service");

endmodule : mpiu_top

// file: rtl/mpiu_pkg.sv
// constants of the microcontroller priority interrupt unit
// Contract
// - four maskable sources plus one non-maskable source with top priority
// - vectors: s0 FFC, s1 FF6, s2 FF4, s3 FF2, s4 FF0
// - non-maskable preempts a maskable routine but not its own; maskable never preempts maskable
// - pending maskable requests served in fixed order, source 1 highest
// - global enable clear blocks maskable sources and all wake-ups
// - non-maskable request latched, latch cleared when its routine starts
// - source 1 level sensitive when select bit set, else falling edge
// - source 2 edge only; polarity bit set rising, clear falling
// - sources 3, 4 and level mode store nothing; sampled after instruction
// - edge latch holds one request until its routine starts
// - requests tested after each instruction; service replaces next one
// - entry swaps flags, pushes pc, inhibits maskable, clears latch, vectors
// - separate flag sets for normal, interrupt and non-maskable modes
// - return restores previous flag set and pops the saved pc
// - option register write-only at C8, full byte, resets to zero
// - option bits 7 and 3 to 0 have no function
// - each ORed event keeps its own flag for software polling
// - source 3 from timer-1 overflow and reload timer overflow, compare
// - source 4 from serial received, serial sent and converter done
// - source 1 from serial peripheral; source 2 from enabled port pins
// - wait or stop refused while an enabled request is pending
package mpiu_pkg;
  localparam logic [7:0] ADDR_OPTION = 8'hC8;
  localparam logic [7:0] ADDR_STATUS = 8'hCC;
  localparam logic [7:0] ADDR_EVENTS = 8'hD0;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam int BIT_SRC1_LEVEL = 6;
  localparam int BIT_SRC2_POL = 5;
  localparam int BIT_GLOBAL_EN = 4;
  localparam int NUM_EVENTS = 7;
  localparam int EV_SPI = 0;
  localparam int EV_T1_OVF = 1;
  localparam int EV_RL_OVF = 2;
  localparam int EV_RL_CMP = 3;
  localparam int EV_RX = 4;
  localparam int EV_TX = 5;
  localparam int EV_EOC = 6;
  localparam logic [11:0] VEC_SRC0 = 12'hFFC;
  localparam logic [11:0] VEC_SRC1 = 12'hFF6;
  localparam logic [11:0] VEC_SRC2 = 12'hFF4;
  localparam logic [11:0] VEC_SRC3 = 12'hFF2;
  localparam logic [11:0] VEC_SRC4 = 12'hFF0;
  typedef enum logic [1:0] {
    MPIU_FLAGS_NORMAL = 2'b00,
    MPIU_FLAGS_INT = 2'b01,
    MPIU_FLAGS_NMI = 2'b10
  } mpiu_flags_e;
endpackage : mpiu_pkg

// file: dv/mpiu_core_model.sv
// core sequencer and peripheral event model facing the interrupt unit
`timescale 1ns/1ns
module mpiu_core_model (
  input wire logic pclk,
  output logic instr_done,
  output logic return_from_interrupt,
  output logic sleep_req,
  output logic [6:0] evt
);
  initial
  begin
    instr_done = 1'h0;
    return_from_interrupt = 1'h0;
    sleep_req = 1'h0;
    evt = 7'h00;
  end

  // one-cycle core strobe: 0 end of instruction, 1 return, 2 sleep
  // routine software saves its own data registers, not modelled
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: instr_done <= 1'h1;
      1: return_from_interrupt <= 1'h1;
      default: sleep_req <= 1'h1;
    endcase
    @(posedge pclk);
    instr_done <= 1'h0;
    return_from_interrupt <= 1'h0;
    sleep_req <= 1'h0;
  endtask : pulse

  // peripheral events are single-cycle pulses
  task automatic fire(input logic [6:0] m);
    @(posedge pclk);
    evt <= m;
    @(posedge pclk);
    evt <= 7'h00;
  endtask : fire
endmodule : mpiu_core_model

// file: dv/tb_mpiu_top.sv
// self-checking bench of the interrupt unit
`timescale 1ns/1ns
module tb_mpiu_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nmi_pin_n;
  logic [11:0] pin_n;
  logic [11:0] pin_en;
  logic [6:0] en;
  logic [6:0] evt;
  logic instr_done;
  logic return_from_interrupt;
  logic sleep_req;
  logic irq_take;
  logic [11:0] irq_vector;
  logic pc_push;
  logic pc_pop;
  logic [1:0] flag_set_sel;
  logic sleeping;
  logic wake;
  logic sleep_refused;
  logic [31:0] rd;
  logic er;
  int err_count;
  int checks_done;

  mpiu_top u_mpiu_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmi_pin_n(nmi_pin_n),
    .port_pin_n(pin_n), .port_pin_irq_en(pin_en),
    .spi_eot_evt(evt[0]), .spi_irq_enable(en[0]),
    .timer1_overflow_evt(evt[1]), .timer1_irq_enable(en[1]),
    .reload_overflow_evt(evt[2]), .reload_overflow_irq_enable(en[2]),
    .reload_compare_evt(evt[3]), .reload_compare_irq_enable(en[3]),
    .serial_rx_evt(evt[4]), .serial_rx_irq_enable(en[4]),
    .serial_tx_evt(evt[5]), .serial_tx_irq_enable(en[5]),
    .converter_eoc_evt(evt[6]), .converter_irq_enable(en[6]),
    .instr_done(instr_done), .return_from_interrupt(return_from_interrupt),
    .sleep_req(sleep_req), .irq_take(irq_take), .irq_vector(irq_vector),
    .pc_push(pc_push), .pc_pop(pc_pop), .flag_set_sel(flag_set_sel),
    .sleeping(sleeping), .wake(wake), .sleep_refused(sleep_refused)
  );

  mpiu_core_model u_mpiu_core_model (
    .pclk(pclk), .instr_done(instr_done),
    .return_from_interrupt(return_from_interrupt),
    .sleep_req(sleep_req), .evt(evt)
  );

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge, for at most 16 cycles
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1)
      err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // one core strobe, then the answer cycle is judged
  task automatic step(input int k, input logic t, input logic [11:0] v,
                      input mpiu_pkg::mpiu_flags_e f);
    u_mpiu_core_model.pulse(k);
    @(posedge pclk);
    if (k == 0)
    begin
      chk("irq_take", 32'(t), 32'(irq_take));
      chk("pc_push", 32'(t), 32'(pc_push));
      if (t)
        chk("irq_vector", 32'(v), 32'(irq_vector));
    end
    else if (k == 1)
      chk("pc_pop", 32'h1, 32'(pc_pop));
    else
    begin
      chk("sleeping", 32'(t), 32'(sleeping));
      chk("sleep_refused", 32'(!t), 32'(sleep_refused));
    end
    chk("flag_set_sel", 32'(f), 32'(flag_set_sel));
  endtask : step

  task automatic t_regs();
    apb(1'h0, mpiu_pkg::ADDR_OPTION, 32'h0);
    chk("option_read", 32'h0, rd);
    chk("option_err", 32'h0, 32'(er));
    apb(1'h0, 8'hF0, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    $display("test regs done");
  endtask : t_regs

  task automatic t_gen_sleep();
    int n;
    logic w;
    w = 1'h0;
    u_mpiu_core_model.fire(7'(1 << mpiu_pkg::EV_T1_OVF));
    step(0, 1'h0, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    step(2, 1'h1, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    nmi_pin_n <= 1'h0;
    repeat (6) @(posedge pclk);
    chk("still_asleep", 32'h1, 32'(sleeping));
    // unused bits set on purpose, they must change nothing
    apb(1'h1, mpiu_pkg::ADDR_OPTION, 32'h0000009F);
    for (n = 0; n < 8; n++)
    begin
      @(posedge pclk);
      if (wake === 1'h1)
        w = 1'h1;
    end
    chk("wake", 32'h1, 32'(w));
    $display("test gen_sleep done");
  endtask : t_gen_sleep

  task automatic t_nmi();
    step(0, 1'h1, mpiu_pkg::VEC_SRC0, mpiu_pkg::MPIU_FLAGS_NMI);
    nmi_pin_n <= 1'h1;
    step(0, 1'h0, 12'h000, mpiu_pkg::MPIU_FLAGS_NMI);
    step(1, 1'h1, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    step(0, 1'h1, mpiu_pkg::VEC_SRC3, mpiu_pkg::MPIU_FLAGS_INT);
    $display("test nmi done");
  endtask : t_nmi

  task automatic t_order();
    u_mpiu_core_model.fire(7'h30);
    pin_n <= 12'hFFE;
    repeat (4) @(posedge pclk);
    step(0, 1'h0, 12'h000, mpiu_pkg::MPIU_FLAGS_INT);
    pin_n <= 12'hFFF;
    apb(1'h0, mpiu_pkg::ADDR_EVENTS, 32'h0);
    chk("event_flags", 32'h32, rd);
    apb(1'h1, mpiu_pkg::ADDR_EVENTS, 32'(1 << mpiu_pkg::EV_T1_OVF));
    step(1, 1'h1, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    step(0, 1'h1, mpiu_pkg::VEC_SRC2, mpiu_pkg::MPIU_FLAGS_INT);
    step(2, 1'h0, 12'h000, mpiu_pkg::MPIU_FLAGS_INT);
    step(1, 1'h1, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    step(0, 1'h1, mpiu_pkg::VEC_SRC4, mpiu_pkg::MPIU_FLAGS_INT);
    // nmi preempts the running maskable routine and returns to it
    nmi_pin_n <= 1'h0;
    repeat (4) @(posedge pclk);
    step(0, 1'h1, mpiu_pkg::VEC_SRC0, mpiu_pkg::MPIU_FLAGS_NMI);
    nmi_pin_n <= 1'h1;
    step(1, 1'h1, 12'h000, mpiu_pkg::MPIU_FLAGS_INT);
    apb(1'h1, mpiu_pkg::ADDR_EVENTS, 32'(1 << mpiu_pkg::EV_RX));
    step(1, 1'h1, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    // disabled tx flag and the spent edge latch must not dispatch
    step(0, 1'h0, 12'h000, mpiu_pkg::MPIU_FLAGS_NORMAL);
    $display("test order done");
  endtask : t_order

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nmi_pin_n = 1'h1;
    pin_n = 12'hFFF;
    pin_en = 12'hFFF;
    // tx event left disabled to show per-event gating
    en = 7'h5F;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_gen_sleep();
    t_nmi();
    t_order();
    wrap_up();
  end

  // a run of about a hundred cycles; reaching the 2000-cycle limit means a hang
  initial
  begin
    #80000;
    err_count++;
    wrap_up();
  end
endmodule : tb_mpiu_top
